/* src/rtc_pkg.sv */
// Purpose: shared constants for the serial real-time clock register core
// Assumes: 16 byte registers, 4-bit register address, one 100 MHz clock
// Notes:   reset values and write masks are per register, indexed by address
//
// Contract
// - sixteen 8-bit registers with a pointer that steps after every data byte moved.
// - the two control and status registers sit at addresses 0 and 1.
// - seconds, minutes, hours, days, weekdays, months, years sit at 2 to 8 in order.
// - seconds, minutes, hours, days, months and years count in packed BCD.
// - the time and date counters are frozen while a serial transfer is in progress.
// - minute, hour, day and weekday alarm registers sit at 9 to 12.
// - the clock output register at 13 selects the programmable output mode.
// - a countdown timer with control at 14 and count at 15 runs from one of four sources.
// - control register two enables a once-per-second and once-per-minute interrupt.
// - the interrupt pin is open drain, pulled low while an interrupt is pending.
// - serial clock and data are ignored while chip enable is low.
// - data in and data out are separate lines that the host may join.
// - the timekeeping clock is the crystal oscillator divided down.
package rtc_pkg;

  localparam int          RTC_NREG    = 16;
  localparam int          RTC_AW      = 4;

  localparam logic [3:0]  ADR_CTRL1   = 4'h0;
  localparam logic [3:0]  ADR_CTRL2   = 4'h1;
  localparam logic [3:0]  ADR_SEC     = 4'h2;
  localparam logic [3:0]  ADR_MIN     = 4'h3;
  localparam logic [3:0]  ADR_HOUR    = 4'h4;
  localparam logic [3:0]  ADR_DAY     = 4'h5;
  localparam logic [3:0]  ADR_WDAY    = 4'h6;
  localparam logic [3:0]  ADR_MON     = 4'h7;
  localparam logic [3:0]  ADR_YEAR    = 4'h8;
  localparam logic [3:0]  ADR_AMIN    = 4'h9;
  localparam logic [3:0]  ADR_AHOUR   = 4'ha;
  localparam logic [3:0]  ADR_ADAY    = 4'hb;
  localparam logic [3:0]  ADR_AWDAY   = 4'hc;
  localparam logic [3:0]  ADR_CLKSEL  = 4'hd;
  localparam logic [3:0]  ADR_TCTRL   = 4'he;
  localparam logic [3:0]  ADR_TVAL    = 4'hf;

  // control_status_one fields
  localparam int          C1_STOP     = 5;
  // control_status_two fields
  localparam int          C2_MI       = 7;
  localparam int          C2_SI       = 6;
  localparam int          C2_MSF      = 5;
  localparam int          C2_AF       = 3;
  localparam int          C2_TF       = 2;
  localparam int          C2_AIE      = 1;
  localparam int          C2_TIE      = 0;
  localparam logic [7:0]  C2_FLAGS    = 8'h2c;
  // alarm enable bit, low means the field takes part in the match
  localparam int          ALM_OFF     = 7;
  localparam int          TC_TE       = 7;
  localparam int          CMD_RD      = 7;

  // bcd limits
  localparam logic [7:0]  BCD_59      = 8'h59;
  localparam logic [7:0]  BCD_23      = 8'h23;
  localparam logic [7:0]  BCD_12      = 8'h12;
  localparam logic [7:0]  BCD_99      = 8'h99;
  localparam logic [7:0]  WDAY_MAX    = 8'h06;

  localparam int          XTAL_HZ     = 32768;
  localparam int          PRE_W       = 15;

  localparam logic [1:0]  TSRC_FAST   = 2'h0;
  localparam logic [1:0]  TSRC_MID    = 2'h1;
  localparam logic [1:0]  TSRC_SEC    = 2'h2;

  localparam logic [RTC_NREG-1:0][7:0] RTC_RST = {
    8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00,
    8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h80, 8'h00, 8'h08};

  // writable bits; the rest read back as zero
  localparam logic [RTC_NREG-1:0][7:0] RTC_WMASK = {
    8'hff, 8'h83, 8'h07, 8'h87, 8'hbf, 8'hbf, 8'hff, 8'hff,
    8'h1f, 8'h07, 8'h3f, 8'h3f, 8'h7f, 8'hff, 8'hff, 8'hac};

endpackage : rtc_pkg

/* src/rtc_spi_slave.sv */
// Purpose: serial port front end, byte framing and auto-increment pointer
// Assumes: spi_clk sampled on sys_clk, data in on rising, out on falling edge
// Notes:   first byte is the command: bit 7 read, bits 3:0 start address
`timescale 1ns/1ps
module rtc_spi_slave
  import rtc_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              chip_en,
  input  wire logic              spi_clk,
  input  wire logic              serial_in,
  output logic                   serial_out,
  output logic                   serial_oe,
  output logic                   busy,
  output logic                   wr_stb,
  output logic [RTC_AW-1:0]      wr_addr,
  output logic [7:0]             wr_data,
  output logic [RTC_AW-1:0]      rd_addr,
  input  wire logic [7:0]        rd_data
);

  typedef enum logic [3:0] {
    SP_IDLE = 4'b0001,
    SP_CMD  = 4'b0010,
    SP_WR   = 4'b0100,
    SP_RD   = 4'b1000
  } rtc_spi_e;

  rtc_spi_e          st_q,   st_d;
  logic              sck_q,  sck_d;
  logic [2:0]        bit_q,  bit_d;
  logic [7:0]        sh_q,   sh_d;
  logic [7:0]        out_q,  out_d;
  logic [RTC_AW-1:0] ptr_q,  ptr_d;
  logic              ld_q,   ld_d;
  logic              new_q,  new_d;
  logic              ws_q,   ws_d;
  logic [RTC_AW-1:0] wa_q,   wa_d;
  logic [7:0]        wd_q,   wd_d;
  logic              rise;
  logic              fall;
  logic [7:0]        byte_in;

  always_comb
  begin
    sck_d   = spi_clk;
    rise    = chip_en & spi_clk & ~sck_q;
    fall    = chip_en & ~spi_clk & sck_q;
    byte_in = {sh_q[6:0], serial_in};
    st_d    = st_q;
    bit_d   = bit_q;
    sh_d    = sh_q;
    out_d   = out_q;
    ptr_d   = ptr_q;
    ld_d    = 1'b0;
    new_d   = new_q;
    ws_d    = 1'b0;
    wa_d    = wa_q;
    wd_d    = wd_q;
    if (!chip_en)
    begin
      st_d  = SP_IDLE;
      bit_d = 3'h0;
    end
    else
    begin
      case (st_q)
        SP_IDLE: st_d = SP_CMD;
        SP_CMD, SP_WR, SP_RD:
        begin
          if (rise)
          begin
            sh_d  = byte_in;
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7)
            begin
              if (st_q == SP_CMD)
              begin
                ptr_d = byte_in[RTC_AW-1:0];
                st_d  = byte_in[CMD_RD] ? SP_RD : SP_WR;
                ld_d  = byte_in[CMD_RD];
              end
              else if (st_q == SP_WR)
              begin
                ws_d  = 1'b1;
                wa_d  = ptr_q;
                wd_d  = byte_in;
                ptr_d = ptr_q + 4'h1;
              end
              else
              begin
                ptr_d = ptr_q + 4'h1;
                ld_d  = 1'b1;
              end
            end
          end
        end
        default: st_d = SP_IDLE;
      endcase
    end
    // the load lands between edges; its first falling edge must not shift it away
    if (ld_q)
    begin
      out_d = rd_data;
      new_d = 1'b1;
    end
    else if (fall)
    begin
      if (new_q)
        new_d = 1'b0;
      else
        out_d = {out_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q  <= SP_IDLE;
      sck_q <= 1'b0;
      bit_q <= 3'h0;
      sh_q  <= 8'h00;
      out_q <= 8'h00;
      ptr_q <= 4'h0;
      ld_q  <= 1'b0;
      new_q <= 1'b0;
      ws_q  <= 1'b0;
      wa_q  <= 4'h0;
      wd_q  <= 8'h00;
    end
    else
    begin
      st_q  <= st_d;
      sck_q <= sck_d;
      bit_q <= bit_d;
      sh_q  <= sh_d;
      out_q <= out_d;
      ptr_q <= ptr_d;
      ld_q  <= ld_d;
      new_q <= new_d;
      ws_q  <= ws_d;
      wa_q  <= wa_d;
      wd_q  <= wd_d;
    end
  end

  assign serial_out = out_q[7];
  assign serial_oe  = chip_en & (st_q == SP_RD);
  assign busy       = chip_en;
  assign wr_stb     = ws_q;
  assign wr_addr    = wa_q;
  assign wr_data    = wd_q;
  assign rd_addr    = ptr_q;

endmodule : rtc_spi_slave

/* src/rtc_core.sv */
// Purpose: real-time clock register file, calendar, alarm, timer, clock output
// Assumes: xtal_in is a synchronous level toggling at the crystal rate
// Notes:   hours count in 24-hour form only; interrupt and clock output pins are open drain
`timescale 1ns/1ps
module rtc_core
  import rtc_pkg::*;
#(
  parameter int XTAL_DIV = XTAL_HZ
)
(
  input  wire logic  sys_clk,
  input  wire logic  rst,
  input  wire logic  chip_en,
  input  wire logic  spi_clk,
  input  wire logic  serial_in,
  output logic       serial_out,
  output logic       serial_oe,
  input  wire logic  xtal_in,
  output logic       xtal_out,
  output logic       int_out,
  output logic       int_oe,
  output logic       prog_freq_out,
  output logic       prog_freq_oe
);

  logic [RTC_NREG-1:0][7:0] regs_q, regs_d;
  logic [PRE_W-1:0]         pre_q,  pre_d;
  logic [PRE_W-1:0]         tap_q,  tap_d;
  logic [7:0]               cnt_q,  cnt_d;
  logic                     xprv_q, xprv_d;
  logic                     pend_q, pend_d;
  logic                     io_q,   io_d;
  logic                     co_q,   co_d;
  logic                     xo_q,   xo_d;

  logic              busy;
  logic              wr_stb;
  logic [RTC_AW-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic [RTC_AW-1:0] rd_addr;
  logic [7:0]        rd_data;

  logic       xedge;
  logic       stop;
  logic       sec_tick;
  logic       go;
  logic       min_tick;
  logic       hr_tick;
  logic       day_tick;
  logic       mon_tick;
  logic       tsrc;
  logic       alm_hit;
  logic       alm_any;
  logic [7:0] hw_set;
  logic [8:0] r9;
  logic       lvl;

  // one bcd step: returns {wrapped, next}
  function automatic logic [8:0] bcd_inc(input logic [7:0] v,
                                         input logic [7:0] maxv,
                                         input logic [7:0] minv);
    logic [8:0] res;
    if (v >= maxv)
      res = {1'b1, minv};
    else if (v[3:0] >= 4'h9)
      res = {1'b0, v[7:4] + 4'h1, 4'h0};
    else
      res = {1'b0, v[7:4], v[3:0] + 4'h1};
    return res;
  endfunction : bcd_inc

  // year in bcd divisible by four
  function automatic logic is_leap(input logic [7:0] yr);
    logic r;
    if (yr[4])
      r = (yr[3:0] == 4'h2) | (yr[3:0] == 4'h6);
    else
      r = (yr[3:0] == 4'h0) | (yr[3:0] == 4'h4) | (yr[3:0] == 4'h8);
    return r;
  endfunction : is_leap

  function automatic logic [7:0] last_day(input logic [7:0] mon,
                                          input logic [7:0] yr);
    logic [7:0] d;
    if (mon == 8'h02)
      d = is_leap(yr) ? 8'h29 : 8'h28;
    else if ((mon == 8'h04) | (mon == 8'h06) | (mon == 8'h09) | (mon == 8'h11))
      d = 8'h30;
    else
      d = 8'h31;
    return d;
  endfunction : last_day

  rtc_spi_slave u_spi (
    .sys_clk    (sys_clk),
    .rst        (rst),
    .chip_en    (chip_en),
    .spi_clk    (spi_clk),
    .serial_in  (serial_in),
    .serial_out (serial_out),
    .serial_oe  (serial_oe),
    .busy       (busy),
    .wr_stb     (wr_stb),
    .wr_addr    (wr_addr),
    .wr_data    (wr_data),
    .rd_addr    (rd_addr),
    .rd_data    (rd_data)
  );

  // timer register reads back the live count, not the reload value
  always_comb
  begin
    if (rd_addr == ADR_TVAL)
      rd_data = cnt_q;
    else
      rd_data = regs_q[rd_addr] & RTC_WMASK[rd_addr];
  end

  always_comb
  begin
    regs_d = regs_q;
    cnt_d  = cnt_q;
    hw_set = 8'h00;
    xprv_d = xtal_in;
    xedge  = xtal_in & ~xprv_q;
    stop   = regs_q[ADR_CTRL1][C1_STOP];
    // prescaler held at zero while stopped
    if (stop)
      pre_d = '0;
    else if (xedge)
      pre_d = (pre_q == PRE_W'(XTAL_DIV - 1)) ? '0 : pre_q + 1'b1;
    else
      pre_d = pre_q;
    sec_tick = xedge & ~stop & (pre_q == PRE_W'(XTAL_DIV - 1));

    // a tick during a transfer waits, so a transfer under one second loses no second and no carry tears
    go     = (sec_tick | pend_q) & ~busy;
    pend_d = (sec_tick | pend_q) & busy;

    min_tick = 1'b0;
    hr_tick  = 1'b0;
    day_tick = 1'b0;
    mon_tick = 1'b0;
    r9       = 9'h000;
    if (go)
    begin
      r9 = bcd_inc({1'b0, regs_q[ADR_SEC][6:0]}, BCD_59, 8'h00);
      regs_d[ADR_SEC][6:0] = r9[6:0];
      min_tick = r9[8];
      if (min_tick)
      begin
        r9 = bcd_inc(regs_q[ADR_MIN], BCD_59, 8'h00);
        regs_d[ADR_MIN] = r9[7:0];
        hr_tick = r9[8];
      end
      if (hr_tick)
      begin
        r9 = bcd_inc(regs_q[ADR_HOUR], BCD_23, 8'h00);
        regs_d[ADR_HOUR] = r9[7:0];
        day_tick = r9[8];
      end
      if (day_tick)
      begin
        r9 = bcd_inc(regs_q[ADR_DAY],
                     last_day(regs_q[ADR_MON], regs_q[ADR_YEAR]), 8'h01);
        regs_d[ADR_DAY] = r9[7:0];
        mon_tick = r9[8];
        regs_d[ADR_WDAY] = (regs_q[ADR_WDAY] >= WDAY_MAX) ? 8'h00
                           : regs_q[ADR_WDAY] + 8'h01;
      end
      if (mon_tick)
      begin
        r9 = bcd_inc(regs_q[ADR_MON], BCD_12, 8'h01);
        regs_d[ADR_MON] = r9[7:0];
        // the year wraps from 99 to 00, there is no century digit
        if (r9[8])
        begin
          r9 = bcd_inc(regs_q[ADR_YEAR], BCD_99, 8'h00);
          regs_d[ADR_YEAR] = r9[7:0];
        end
      end
    end

    // alarm checked on the new minute; a field with its off bit set is skipped
    alm_any = ~(regs_q[ADR_AMIN][ALM_OFF] & regs_q[ADR_AHOUR][ALM_OFF]
              & regs_q[ADR_ADAY][ALM_OFF] & regs_q[ADR_AWDAY][ALM_OFF]);
    alm_hit = min_tick & alm_any
      & (regs_q[ADR_AMIN][ALM_OFF]  | (regs_q[ADR_AMIN][6:0]  == regs_d[ADR_MIN][6:0]))
      & (regs_q[ADR_AHOUR][ALM_OFF] | (regs_q[ADR_AHOUR][5:0] == regs_d[ADR_HOUR][5:0]))
      & (regs_q[ADR_ADAY][ALM_OFF]  | (regs_q[ADR_ADAY][5:0]  == regs_d[ADR_DAY][5:0]))
      & (regs_q[ADR_AWDAY][ALM_OFF] | (regs_q[ADR_AWDAY][2:0] == regs_d[ADR_WDAY][2:0]));
    hw_set[C2_AF] = alm_hit;

    hw_set[C2_MSF] = (go & regs_q[ADR_CTRL2][C2_SI])
                   | (min_tick & regs_q[ADR_CTRL2][C2_MI]);

    // countdown source select
    case (regs_q[ADR_TCTRL][1:0])
      TSRC_FAST: tsrc = xedge & ~stop & (&tap_q[2:0]);
      TSRC_MID:  tsrc = xedge & ~stop & (&tap_q[8:0]);
      TSRC_SEC:  tsrc = go;
      default:   tsrc = min_tick;
    endcase
    if (regs_q[ADR_TCTRL][TC_TE] & tsrc)
    begin
      if (cnt_q <= 8'h01)
      begin
        cnt_d = regs_q[ADR_TVAL];
        hw_set[C2_TF] = 1'b1;
      end
      else
        cnt_d = cnt_q - 8'h01;
    end

    // host write beats the counting step for the same register
    if (wr_stb)
    begin
      if (wr_addr == ADR_CTRL2)
        regs_d[ADR_CTRL2] = (wr_data & ~C2_FLAGS)
                          | (wr_data & regs_q[ADR_CTRL2] & C2_FLAGS);
      else
        regs_d[wr_addr] = wr_data & RTC_WMASK[wr_addr];
      if (wr_addr == ADR_TVAL)
        cnt_d = wr_data;
    end
    // a flag raised in the cycle it is cleared survives
    regs_d[ADR_CTRL2] = regs_d[ADR_CTRL2] | hw_set;

    io_d = (regs_q[ADR_CTRL2][C2_MSF]
            & (regs_q[ADR_CTRL2][C2_MI] | regs_q[ADR_CTRL2][C2_SI]))
         | (regs_q[ADR_CTRL2][C2_AF] & regs_q[ADR_CTRL2][C2_AIE])
         | (regs_q[ADR_CTRL2][C2_TF] & regs_q[ADR_CTRL2][C2_TIE]);

    // output mode: crystal, divided taps, or released
    case (regs_q[ADR_CLKSEL][2:0])
      3'h0:    lvl = xtal_in;
      3'h1:    lvl = tap_q[0];
      3'h2:    lvl = tap_q[1];
      3'h3:    lvl = tap_q[2];
      3'h4:    lvl = tap_q[4];
      3'h5:    lvl = tap_q[9];
      3'h6:    lvl = tap_q[14];
      default: lvl = 1'b1;
    endcase
    co_d = ~lvl;
    xo_d = ~xtal_in;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      regs_q <= RTC_RST;
      pre_q  <= '0;
      cnt_q  <= 8'h00;
      xprv_q <= 1'b0;
      pend_q <= 1'b0;
      io_q   <= 1'b0;
      co_q   <= 1'b0;
      xo_q   <= 1'b1;
    end
    else
    begin
      regs_q <= regs_d;
      pre_q  <= pre_d;
      cnt_q  <= cnt_d;
      xprv_q <= xprv_d;
      pend_q <= pend_d;
      io_q   <= io_d;
      co_q   <= co_d;
      xo_q   <= xo_d;
    end
  end

  // taps for clock output and timer come from a power-of-two divider of their
  // own, so a shortened second divider still leaves every tap toggling
  always_comb
  begin
    // stop clears it along with the rest of the divider chain
    if (stop)
      tap_d = '0;
    else if (xedge)
      tap_d = tap_q + 1'b1;
    else
      tap_d = tap_q;
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      tap_q <= '0;
    else
      tap_q <= tap_d;
  end

  // open drain: interrupt and clock output only ever pull low; crystal drive is push-pull
  assign int_out       = 1'b0;
  assign int_oe        = io_q;
  assign prog_freq_out = 1'b0;
  assign prog_freq_oe  = co_q;
  assign xtal_out      = xo_q;

endmodule : rtc_core

/* verification/rtc_core_monitor.sv */
// Purpose: port-level assertions for the rtc register core
// Assumes: sees only the top module ports, one clock domain
// Notes:   bound into every instance of the core
`timescale 1ns/1ps
module rtc_core_monitor
  import rtc_pkg::*;
#(
  parameter int XTAL_DIV = XTAL_HZ
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic chip_en,
  input wire logic spi_clk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_oe,
  input wire logic xtal_in,
  input wire logic xtal_out,
  input wire logic int_out,
  input wire logic int_oe,
  input wire logic prog_freq_out,
  input wire logic prog_freq_oe
);
  default clocking mon_cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  oe_idle_a: assert property (!chip_en |-> !serial_oe)
    else $error("data out driven while deselected");
  cmd_first_a: assert property ($rose(chip_en) |-> !serial_oe [*8])
    else $error("data out driven before the command byte");
  oe_cause_a: assert property ($rose(serial_oe) |->
    $past(spi_clk) || $past(spi_clk, 2) || $past(spi_clk, 3))
    else $error("read byte loaded without a serial clock rise");
  sdo_hold_a: assert property (chip_en && $past(chip_en, 3) && !spi_clk &&
    !$past(spi_clk) && !$past(spi_clk, 2) && !$past(spi_clk, 3) |-> $stable(serial_out))
    else $error("data out moved inside a low serial clock phase");
  int_od_a: assert property (int_oe |-> !int_out)
    else $error("interrupt pin driven high");
  clk_od_a: assert property (prog_freq_oe |-> !prog_freq_out)
    else $error("clock output pin driven high");
  xtal_inv_a: assert property (!$past(rst) |-> xtal_out == !$past(xtal_in))
    else $error("crystal drive is not the inverted input");
  reset_quiet_a: assert property ($fell(rst) |->
    !int_oe && !prog_freq_oe && xtal_out && !serial_oe)
    else $error("pins not idle after reset");
endmodule : rtc_core_monitor

bind rtc_core rtc_core_monitor #(
  .XTAL_DIV      (XTAL_DIV)
) i_rtc_core_monitor (
  .sys_clk       (sys_clk),
  .rst           (rst),
  .chip_en       (chip_en),
  .spi_clk       (spi_clk),
  .serial_in     (serial_in),
  .serial_out    (serial_out),
  .serial_oe     (serial_oe),
  .xtal_in       (xtal_in),
  .xtal_out      (xtal_out),
  .int_out       (int_out),
  .int_oe        (int_oe),
  .prog_freq_out (prog_freq_out),
  .prog_freq_oe  (prog_freq_oe)
);

/* verification/rtc_host_model.sv */
// Purpose: host processor model, master of the serial port
// Assumes: half period of 4 sys_clk, data taken on the rising serial clock
// Notes:   serial clock stands low between frames
`timescale 1ns/1ps
module rtc_host_model
(
  input  wire logic sys_clk,
  output logic      chip_en,
  output logic      spi_clk,
  output logic      serial_in,
  input  wire logic sdo_w
);
  localparam int HALF = 4;

  initial
  begin
    chip_en   = 1'b0;
    spi_clk   = 1'b0;
    serial_in = 1'b0;
  end

  // a floating input is never held at its last bit
  always @(posedge sys_clk)
    if (!chip_en)
      serial_in <= ~serial_in;

  task automatic sel(input logic on);
    @(posedge sys_clk);
    chip_en <= on;
    repeat (HALF) @(posedge sys_clk);
  endtask : sel

  // serial clock toggles while the device is deselected
  task automatic wiggle(input int n);
    repeat (n)
    begin
      repeat (HALF) @(posedge sys_clk);
      spi_clk <= ~spi_clk;
    end
  endtask : wiggle

  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      serial_in <= tx[i];
      repeat (HALF) @(posedge sys_clk);
      rx[i] = sdo_w;
      spi_clk <= 1'b1;
      repeat (HALF) @(posedge sys_clk);
      spi_clk <= 1'b0;
    end
  endtask : bits
endmodule : rtc_host_model

/* verification/rtc_core_bench.sv */
// Purpose: self-checking bench for the rtc register core
// Assumes: crystal cycle of 4 sys_clk, one second shortened to 8 of them
// Notes:   clock output counts allow one edge of phase slack
`timescale 1ns/1ps
module rtc_core_bench
  import rtc_pkg::*;
();
  localparam int XDIV  = 8;
  localparam int LIMIT = 60000;
  logic       sys_clk;
  logic       rst;
  logic       xtal_in;
  logic       pin_q;
  wire        chip_en, spi_clk, serial_in, serial_out, serial_oe, xtal_out;
  wire        int_out, int_oe, prog_freq_out, prog_freq_oe;
  wire        sdo_w   = serial_oe ? serial_out : 1'bz;
  wire        int_n   = int_oe ? int_out : 1'b1;
  wire        clk_pin = prog_freq_oe ? prog_freq_out : 1'b1;
  int         n_fail  = 0;
  int         checks_done = 0;
  int         cyc     = 0;
  int         nfall   = 0;

  rtc_core #(
    .XTAL_DIV      (XDIV)
  ) i_rtc_core (
    .sys_clk       (sys_clk),
    .rst           (rst),
    .chip_en       (chip_en),
    .spi_clk       (spi_clk),
    .serial_in     (serial_in),
    .serial_out    (serial_out),
    .serial_oe     (serial_oe),
    .xtal_in       (xtal_in),
    .xtal_out      (xtal_out),
    .int_out       (int_out),
    .int_oe        (int_oe),
    .prog_freq_out (prog_freq_out),
    .prog_freq_oe  (prog_freq_oe)
  );

  rtc_host_model i_host (
    .sys_clk   (sys_clk),
    .chip_en   (chip_en),
    .spi_clk   (spi_clk),
    .serial_in (serial_in),
    .sdo_w     (sdo_w)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    pin_q <= clk_pin;
    if (pin_q && !clk_pin)
      nfall++;
    if (++cyc > LIMIT)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic xtal(input int n);
    repeat (n)
    begin
      @(posedge sys_clk);
      xtal_in <= 1'b1;
      repeat (2) @(posedge sys_clk);
      xtal_in <= 1'b0;
      @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
  endtask : xtal

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] v;
    i_host.sel(1'b1);
    i_host.bits({4'h0, a}, 8, v);
    i_host.bits(d, 8, v);
    i_host.sel(1'b0);
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    i_host.sel(1'b1);
    i_host.bits({4'h8, a}, 8, v);
    i_host.bits(8'h00, 8, v);
    i_host.sel(1'b0);
    check(v, e);
  endtask : rdchk

  // one burst of 17 bytes: the seventeenth comes from address 0 again
  task automatic t_reset_regs();
    logic [7:0] v;
    i_host.sel(1'b1);
    i_host.bits(8'h80, 8, v);
    for (int i = 0; i < 17; i++)
    begin
      i_host.bits(8'h00, 8, v);
      check(v, RTC_RST[i % 16]);
    end
    i_host.sel(1'b0);
  endtask : t_reset_regs

  task automatic t_freeze();
    logic [7:0] v;
    logic [7:0] tv [7] = '{8'h59, 8'h59, 8'h23, 8'h05, 8'h03, 8'h07, 8'h24};
    logic [7:0] nv [7] = '{8'h00, 8'h00, 8'h00, 8'h06, 8'h04, 8'h07, 8'h24};
    i_host.sel(1'b1);
    i_host.bits({4'h0, ADR_SEC}, 8, v);
    foreach (tv[i])
      i_host.bits(tv[i], 8, v);
    i_host.sel(1'b0);
    i_host.sel(1'b1);
    i_host.bits({4'h8, ADR_SEC}, 8, v);
    xtal(XDIV);
    foreach (tv[i])
    begin
      i_host.bits(8'h00, 8, v);
      check(v, tv[i]);
    end
    i_host.sel(1'b0);
    foreach (nv[i])
      rdchk(ADR_SEC + 4'(i), nv[i]);
  endtask : t_freeze

  task automatic t_int();
    wr(ADR_CTRL2, 8'h80);
    wr(ADR_SEC, 8'h58);
    xtal(XDIV);
    check({7'h0, int_n}, 8'h01);
    xtal(XDIV);
    check({7'h0, int_n}, 8'h00);
    wr(ADR_CTRL2, 8'h40);
    check({7'h0, int_n}, 8'h01);
    xtal(XDIV);
    check({7'h0, int_n}, 8'h00);
    wr(ADR_CTRL2, 8'h00);
    check({7'h0, int_n}, 8'h01);
  endtask : t_int

  task automatic t_prog_freq_out();
    logic [2:0] code [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
    int         e    [6] = '{64, 32, 16, 8, 2, 0};
    int         n;
    foreach (code[i])
    begin
      wr(ADR_CLKSEL, {5'h00, code[i]});
      n = nfall;
      xtal(64);
      n = nfall - n;
      check(8'(n + 1 >= e[i] && n <= e[i] + 1), 8'h01);
    end
  endtask : t_prog_freq_out

  task automatic t_timer();
    int p [4] = '{8, 512, XDIV, 60 * XDIV};
    wr(ADR_CTRL2, 8'h01);
    for (int s = 0; s < 4; s++)
    begin
      wr(ADR_TVAL, 8'h02);
      wr(ADR_TCTRL, {6'h20, s[1:0]});
      xtal(1);
      check({7'h0, int_n}, 8'h01);
      xtal(3 * p[s]);
      check({7'h0, int_n}, 8'h00);
      wr(ADR_TCTRL, 8'h00);
      wr(ADR_CTRL2, 8'h01);
      check({7'h0, int_n}, 8'h01);
    end
  endtask : t_timer

  // half a data byte then deselect: nothing may be written
  task automatic t_partial();
    logic [7:0] v;
    wr(ADR_AMIN, 8'h95);
    i_host.wiggle(16);
    i_host.sel(1'b1);
    i_host.bits({4'h0, ADR_AMIN}, 8, v);
    i_host.bits(8'h42, 4, v);
    i_host.sel(1'b0);
    rdchk(ADR_AMIN, 8'h95);
  endtask : t_partial

  // minute alarm only: no flag on a non-matching minute, flag on the match
  task automatic t_alarm();
    wr(ADR_CTRL2, 8'h02);
    wr(ADR_MIN, 8'h10);
    wr(ADR_SEC, 8'h59);
    wr(ADR_AMIN, 8'h12);
    xtal(XDIV);
    check({7'h0, int_n}, 8'h01);
    wr(ADR_SEC, 8'h59);
    xtal(XDIV);
    check({7'h0, int_n}, 8'h00);
    wr(ADR_CTRL2, 8'h02);
    check({7'h0, int_n}, 8'h01);
  endtask : t_alarm

  initial
  begin
    rst = 1'b1;
    xtal_in = 1'b0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset_regs();
    t_freeze();
    t_int();
    t_prog_freq_out();
    t_timer();
    t_partial();
    t_alarm();
    give_verdict();
  end
endmodule : rtc_core_bench
